// >>> sim/demod_model.sv
// Demodulator model: bit clock and MSB-first block stream
`timescale 1ns/1ps
module demod_model (
   // Link to the block
   output logic bit_clk_out,
   output logic data_out
);
   import rds_pkg::*;
   initial begin
      bit_clk_out = 1'b0;
      data_out = 1'b0;
   end
   // One bit per rising edge, clock idle low, data inverted when idle
   task automatic tick(input logic b);
      data_out = b;
      #3 bit_clk_out = 1'b1;
      #3 bit_clk_out = 1'b0;
      data_out = ~b;
   endtask : tick
   // Info word then remainder of info times x^10 xor offset
   task automatic send(input logic [15:0] info, input logic [9:0] ofs,
                       input logic [25:0] err);
      logic [9:0] r;
      logic [25:0] w;
      r = 10'h000;
      for (int i = 15; i >= 0; i--) begin
         r = {r[8:0], 1'b0} ^ ((r[9] ^ info[i]) ? GEN_LOW : 10'h000);
      end
      w = {info, r ^ ofs} ^ err;
      for (int i = 25; i >= 0; i--) begin
         tick(w[i]);
      end
   endtask : send
endmodule : demod_model

// >>> sim/sync_properties.sv
// Concurrent checks on delivery and flag ports
`timescale 1ns/1ps
module sync_checker (
   // Watched ports
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic block_ready_in,
   input wire rds_pkg::block_rec_type block_out,
   input wire logic block_valid_out,
   input wire logic error_n_out,
   input wire logic error_oe_out,
   input wire logic corrected_n_out,
   input wire logic corrected_oe_out,
   input wire logic receive_n_out,
   input wire logic receive_oe_out
);
   import rds_pkg::*;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_error_oe_pair: assert property (error_oe_out == !error_n_out)
      else $error("error enable disagrees with level");
   a_recv_oe_pair: assert property (receive_oe_out == !receive_n_out)
      else $error("receive enable disagrees with level");
   a_corr_oe_pair: assert property (corrected_oe_out == !corrected_n_out)
      else $error("corrected enable disagrees with level");
   a_block_held: assert property (block_valid_out && !block_ready_in |=>
      block_valid_out && $stable(block_out))
      else $error("stalled block changed");
   a_flags_held: assert property (block_valid_out && !block_ready_in |=>
      $stable(error_n_out) && $stable(corrected_n_out))
      else $error("flags changed while stalled");
   a_error_tracks_bad: assert property (block_valid_out |->
      error_n_out == !block_out.bad)
      else $error("error flag does not match block");
   a_fixed_shows: assert property (block_valid_out |->
      corrected_n_out == !block_out.fixed)
      else $error("corrected flag does not match block");
   a_reset_idle: assert property ($fell(sys_rst_in) |->
      !block_valid_out && receive_n_out && error_n_out)
      else $error("outputs not idle after reset");
   c_fixed_block: cover property (block_valid_out && block_out.fixed);
   c_bad_block: cover property (block_valid_out && block_out.bad);
   c_lock: cover property ($fell(receive_n_out));
endmodule : sync_checker
bind rds_group_sync_error_correct sync_checker u_sync_checker (.core_clk_in,
   .sys_rst_in, .block_ready_in, .block_out, .block_valid_out, .error_n_out,
   .error_oe_out, .corrected_n_out, .corrected_oe_out, .receive_n_out,
   .receive_oe_out);

// >>> sim/testbench.sv
// Testbench: streams groups through the demodulator model
`timescale 1ns/1ps
module testbench;
   import rds_pkg::*;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic correction_select_in = 1'b1;
   logic block_ready_in = 1'b0;
   logic bit_clk, data, block_valid_out, error_n_out, corrected_n_out;
   logic receive_n_out;
   block_rec_type block_out, e;
   block_rec_type exp_q[$];
   logic [9:0] ofs_t [4] = '{OFS_A, OFS_B, OFS_C, OFS_D};
   int mismatches = 0;
   int num_checks = 0;
   demod_model u_demod_model (.bit_clk_out(bit_clk), .data_out(data));
   rds_group_sync_error_correct u_rds_group_sync_error_correct (
      .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .bit_clk_in(bit_clk), .data_in(data),
      .correction_select_in(correction_select_in), .block_out(block_out),
      .block_valid_out(block_valid_out), .block_ready_in(block_ready_in),
      .error_n_out(error_n_out), .error_oe_out(), .corrected_n_out(corrected_n_out),
      .corrected_oe_out(), .receive_n_out(receive_n_out), .receive_oe_out());
   initial forever #2 core_clk_in = ~core_clk_in;
   always @(negedge core_clk_in) block_ready_in <= 1'($urandom_range(0, 1));
   task automatic check(input string what, input logic [19:0] ex,
                        input logic [19:0] got);
      num_checks++;
      if (ex !== got) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, ex, got);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // Note the expected record if ex is set, then send the block
   task automatic blk(input logic [1:0] s, input logic [9:0] ofs,
                      input logic [25:0] err, input logic fx, input logic bd,
                      input logic ex);
      logic [15:0] info;
      info = 16'($urandom);
      if (ex) exp_q.push_back('{bd ? info ^ err[25:10] : info, s, fx, bd});
      u_demod_model.send(info, ofs, err);
   endtask : blk
   always @(posedge core_clk_in) begin
      if (!sys_rst_in && block_valid_out === 1'b1 && block_ready_in === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected block", 20'h0, 20'h1);
         else begin
            e = exp_q.pop_front();
            check("block", e, block_out);
            check("error flag", 20'(!e.bad), 20'(error_n_out));
            check("corrected flag", 20'(!e.fixed), 20'(corrected_n_out));
         end
      end
   end
   initial begin
      #20000;
      mismatches++;
      conclude();
   end
   initial begin
      void'($urandom(32'h60C8));
      repeat (6) u_demod_model.tick(1'b0);
      @(negedge core_clk_in) sys_rst_in = 1'b0;
      repeat (3) u_demod_model.tick(1'b0);
      check("receive idle", 20'h1, 20'(receive_n_out));
      for (int s = 0; s < 4; s++) blk(2'(s), ofs_t[s], 26'h0, 0, 0, 1);
      check("receive locked", 20'h0, 20'(receive_n_out));
      blk(2'h0, OFS_A, 26'h0, 0, 0, 1);
      blk(2'h1, OFS_B, 26'h1F << 14, 1, 0, 1);
      blk(2'h2, OFS_CP, 26'h0, 0, 0, 1);
      blk(2'h3, OFS_D, 26'h0, 0, 0, 1);
      exp_q.push_back('{16'h0000, 2'h0, 1'b0, 1'b0});
      u_demod_model.send(16'h0000, OFS_E, 26'h0);
      for (int s = 1; s < 4; s++) blk(2'(s), OFS_E, 26'h0, 0, 0, 1);
      @(negedge core_clk_in) correction_select_in = 1'b0;
      for (int s = 0; s < 4; s++) blk(2'(s), ofs_t[s], 26'(s == 2) << 20, 0,
         s == 2, 1);
      for (int s = 0; s < 5; s++) blk(2'(s), ofs_t[s % 4], 26'h1, 0, 1, s < 4);
      blk(2'h3, OFS_D, 26'h0, 0, 0, 0);
      check("receive lost", 20'h1, 20'(receive_n_out));
      @(negedge core_clk_in) correction_select_in = 1'b1;
      blk(2'h0, OFS_A, 26'h0, 0, 0, 0);
      blk(2'h1, OFS_B, 26'h0, 0, 0, 1);
      blk(2'h2, OFS_C, 26'h0, 0, 0, 1);
      repeat (4) u_demod_model.tick(1'b0);
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge core_clk_in);
      check("pending blocks", 20'h0, 20'(exp_q.size()));
      conclude();
   end
endmodule : testbench

// >>> src/rds_group_sync_error_correct.sv
// Group sync, burst correction, block delivery FIFO and top module
// Function
// R1: Sync is declared when two of three consecutive blocks carry offsets in order.
// R2: Sync reached on an A block starts delivery with the B block of that group.
// R3: Sync reached on a B, C or D block starts delivery with that group's A block.
// R4: Five consecutive blocks without offset drop sync and stop delivery.
// R5: With correction on, error bursts of up to five bits are corrected.
// R6: An all-zero block counts as an E offset block and can be synced on.
// R7: Changes between E groups and ABCD groups keep sync and add no errors.
// R8: The correction select input off leaves data raw, on enables correction.
// R9: The error flag goes low for a delivered block left with errors.
// R10: The reception flag is low while synced data is delivered, else high.
// R11: A block is 26 bits, 16 information bits then a 10-bit checkword.
`timescale 1ns/1ps
module block_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16
) (
   // Filling side
   input wire logic wr_clk_in,
   input wire logic wr_rst_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   // Draining side
   input wire logic rd_clk_in,
   input wire logic rd_rst_in,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(DEPTH);

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wbin_reg;
   logic [AW:0] wgray_reg;
   logic [AW:0] rbin_reg;
   logic [AW:0] rgray_reg;
   logic [AW:0] rg_s1_reg;
   logic [AW:0] rg_s2_reg;
   logic [AW:0] wg_s1_reg;
   logic [AW:0] wg_s2_reg;

   wire logic [AW:0] wbin_next = wbin_reg + 1'b1;
   wire logic [AW:0] rbin_next = rbin_reg + 1'b1;
   wire logic full = wgray_reg ==
      {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
   wire logic empty = rgray_reg == wg_s2_reg;
   wire logic do_wr = wr_valid_in && !full;
   wire logic do_rd = rd_ready_in && !empty;

   assign wr_ready_out = !full;
   assign rd_valid_out = !empty;
   assign rd_data_out = mem[rbin_reg[AW-1:0]];

   // Storage
   always_ff @(posedge wr_clk_in) begin
      if (do_wr) begin
         mem[wbin_reg[AW-1:0]] <= wr_data_in;
      end
   end

   // Write pointer and read pointer crossing
   always_ff @(posedge wr_clk_in) begin
      if (wr_rst_in) begin
         wbin_reg <= '0;
         wgray_reg <= '0;
         rg_s1_reg <= '0;
         rg_s2_reg <= '0;
      end else begin
         rg_s1_reg <= rgray_reg;
         rg_s2_reg <= rg_s1_reg;
         if (do_wr) begin
            wbin_reg <= wbin_next;
            wgray_reg <= to_gray(wbin_next);
         end
      end
   end

   // Read pointer and write pointer crossing
   always_ff @(posedge rd_clk_in) begin
      if (rd_rst_in) begin
         rbin_reg <= '0;
         rgray_reg <= '0;
         wg_s1_reg <= '0;
         wg_s2_reg <= '0;
      end else begin
         wg_s1_reg <= wgray_reg;
         wg_s2_reg <= wg_s1_reg;
         if (do_rd) begin
            rbin_reg <= rbin_next;
            rgray_reg <= to_gray(rbin_next);
         end
      end
   end
endmodule : block_fifo

module rds_group_sync_error_correct (
   // Core clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Demodulator link
   input wire logic bit_clk_in,
   input wire logic data_in,
   // Mode
   input wire logic correction_select_in,
   // Delivered blocks
   output rds_pkg::block_rec_type block_out,
   output logic block_valid_out,
   input wire logic block_ready_in,
   // Open-drain style flags
   output logic error_n_out,
   output logic error_oe_out,
   output logic corrected_n_out,
   output logic corrected_oe_out,
   output logic receive_n_out,
   output logic receive_oe_out
);
   import rds_pkg::*;

   // Burst trap on the error syndrome, then decoded record
   function automatic block_rec_type decode(input logic [25:0] w,
                                            input logic [1:0] pos,
                                            input logic cen);
      block_rec_type r;
      logic [9:0] s;
      logic [9:0] t;
      logic [35:0] ev;
      logic [25:0] err;
      logic [25:0] fixed_w;
      logic found;
      s = syndrome(w);
      t = s ^ offset_of(pos);
      err = '0;
      found = block_hit(s, pos); // see R6 see R7
      if (!found && cen) begin // see R8
         for (int p = 0; p < BLOCK_BITS; p++) begin
            ev = {26'h0000000, t} << p;
            if (!found && t[0] && t[9:BURST_MAX] == 5'h00 &&
                ev[35:26] == 10'h000) begin // see R5
               found = 1'b1;
               err = ev[25:0];
            end
            t = {1'b0, t[9:1]} ^ (t[0] ? GEN_INV : 10'h000);
         end
      end
      fixed_w = w ^ err;
      r.data = fixed_w[BLOCK_BITS-1:CHECK_BITS]; // see R11
      r.pos = pos;
      r.fixed = cen && (err != 26'h0000000 || !found);
      r.bad = !found;
      return r;
   endfunction : decode

   // Link side synchronisers
   logic lrst_s1_reg;
   logic lrst_s2_reg;
   logic din_s1_reg;
   logic din_s2_reg;
   logic cs_s1_reg;
   logic cs_s2_reg;

   // Link side state
   logic [HIST_BITS-1:0] hist_reg;
   logic [HIST_BITS-1:0] snap_reg;
   logic [HIST_BITS-1:0] snap_next;
   sync_state_type state_reg;
   sync_state_type state_next;
   logic [1:0] pos_reg;
   logic [1:0] pos_next;
   logic [1:0] snap_pos_reg;
   logic [1:0] snap_pos_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic conf_reg;
   logic conf_next;
   logic [2:0] miss_reg;
   logic [2:0] miss_next;
   logic [2:0] pend_reg;
   logic [2:0] pend_next;
   logic lock_link_reg;
   logic fifo_wr_ready;

   // Core side
   logic lock_s1_reg;
   logic lock_s2_reg;
   logic [REC_BITS-1:0] fifo_rd_data;
   logic fifo_rd_valid;

   wire logic [25:0] win = hist_reg[BLOCK_BITS-1:0];
   wire logic [9:0] win_syn = syndrome(win);
   wire logic [2:0] hunt = hunt_code(win_syn);
   wire logic at_edge = cnt_reg == CNT_BLOCK;
   wire logic [1:0] npos = pos_reg + 2'h1;
   wire logic nhit = block_hit(win_syn, npos);
   wire logic [2:0] miss_inc = miss_reg + 3'h1;
   wire logic [1:0] sel = pend_reg[1:0] - 2'h1;
   wire logic [6:0] pick_base = {5'h00, sel} * 7'h1A;
   wire logic [25:0] pick = snap_reg[pick_base +: BLOCK_BITS];
   wire logic [1:0] pick_pos = snap_pos_reg - sel;
   wire block_rec_type push_rec = decode(pick, pick_pos, cs_s2_reg);
   wire logic push_valid = pend_reg != 3'h0;
   wire logic fifo_rd_ready = !block_valid_out || block_ready_in;
   wire logic pop = fifo_rd_valid && fifo_rd_ready;
   wire block_rec_type pop_rec = fifo_rd_data;

   // Sync hunt, confirmation, lock and replay of held blocks
   always_comb begin
      state_next = state_reg;
      pos_next = pos_reg;
      cnt_next = at_edge ? CNT_START : cnt_reg + 5'h01;
      conf_next = conf_reg;
      miss_next = miss_reg;
      snap_next = snap_reg;
      snap_pos_next = snap_pos_reg;
      pend_next = pend_reg;
      if (push_valid && fifo_wr_ready) begin
         pend_next = pend_reg - 3'h1;
      end
      case (state_reg)
         ST_HUNT: begin
            if (!at_edge) begin
               cnt_next = cnt_reg + 5'h01;
            end else if (hunt[2]) begin // see R6
               state_next = ST_CONF;
               pos_next = hunt[1:0];
               cnt_next = CNT_START;
               conf_next = 1'b0;
            end else begin
               cnt_next = CNT_BLOCK;
            end
         end
         ST_CONF: begin
            if (at_edge) begin
               pos_next = npos;
               if (nhit) begin // see R1
                  state_next = ST_LOCK;
                  miss_next = 3'h0;
                  snap_next = hist_reg;
                  snap_pos_next = npos;
                  if (npos == 2'h0) begin
                     pend_next = 3'h0; // see R2
                  end else begin
                     pend_next = {1'b0, npos} + 3'h1; // see R3
                  end
               end else if (conf_reg) begin
                  state_next = ST_HUNT;
                  cnt_next = CNT_BLOCK;
               end else begin
                  conf_next = 1'b1;
               end
            end
         end
         ST_LOCK: begin
            if (at_edge) begin
               pos_next = npos;
               miss_next = nhit ? 3'h0 : miss_inc; // see R7
               if (!nhit && miss_inc >= LOSS_BLOCKS) begin // see R4
                  state_next = ST_HUNT;
                  cnt_next = CNT_BLOCK;
                  pend_next = 3'h0;
               end else begin
                  snap_next = hist_reg;
                  snap_pos_next = npos;
                  pend_next = 3'h1;
               end
            end
         end
         default: begin
            state_next = ST_HUNT;
         end
      endcase
   end

   // Link synchronisers
   always_ff @(posedge bit_clk_in) begin
      lrst_s1_reg <= sys_rst_in;
      lrst_s2_reg <= lrst_s1_reg;
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
      cs_s1_reg <= correction_select_in;
      cs_s2_reg <= cs_s1_reg;
   end

   // Link state registers
   always_ff @(posedge bit_clk_in) begin
      if (lrst_s2_reg) begin
         hist_reg <= '0;
         snap_reg <= '0;
         state_reg <= ST_HUNT;
         pos_reg <= 2'h0;
         snap_pos_reg <= 2'h0;
         cnt_reg <= 5'h00;
         conf_reg <= 1'b0;
         miss_reg <= 3'h0;
         pend_reg <= 3'h0;
         lock_link_reg <= 1'b0;
      end else begin
         hist_reg <= {hist_reg[HIST_BITS-2:0], din_s2_reg}; // see R11
         snap_reg <= snap_next;
         state_reg <= state_next;
         pos_reg <= pos_next;
         snap_pos_reg <= snap_pos_next;
         cnt_reg <= cnt_next;
         conf_reg <= conf_next;
         miss_reg <= miss_next;
         pend_reg <= pend_next;
         lock_link_reg <= state_next == ST_LOCK;
      end
   end

   block_fifo #(
      .WIDTH(REC_BITS),
      .DEPTH(FIFO_DEPTH)
   ) fifo_inst (
      .wr_clk_in(bit_clk_in),
      .wr_rst_in(lrst_s2_reg),
      .wr_data_in(push_rec),
      .wr_valid_in(push_valid),
      .wr_ready_out(fifo_wr_ready),
      .rd_clk_in(core_clk_in),
      .rd_rst_in(sys_rst_in),
      .rd_data_out(fifo_rd_data),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(fifo_rd_ready)
   );

   // Output registers
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         lock_s1_reg <= 1'b0;
         lock_s2_reg <= 1'b0;
         block_out <= '0;
         block_valid_out <= 1'b0;
         error_n_out <= 1'b1;
         error_oe_out <= 1'b0;
         corrected_n_out <= 1'b1;
         corrected_oe_out <= 1'b0;
         receive_n_out <= 1'b1;
         receive_oe_out <= 1'b0;
      end else begin
         lock_s1_reg <= lock_link_reg;
         lock_s2_reg <= lock_s1_reg;
         receive_n_out <= !lock_s2_reg; // see R10
         receive_oe_out <= lock_s2_reg;
         if (pop) begin
            block_out <= pop_rec;
            block_valid_out <= 1'b1;
            error_n_out <= !pop_rec.bad; // see R9
            error_oe_out <= pop_rec.bad;
            corrected_n_out <= !pop_rec.fixed;
            corrected_oe_out <= pop_rec.fixed;
         end else if (block_ready_in) begin
            block_valid_out <= 1'b0;
         end
      end
   end
endmodule : rds_group_sync_error_correct

// >>> src/rds_pkg.sv
// Constants, types and code functions for the group sync block
package rds_pkg;
   localparam int BLOCK_BITS = 26;
   localparam int INFO_BITS = 16;
   localparam int CHECK_BITS = 10;
   localparam int HIST_BLOCKS = 4;
   localparam int HIST_BITS = BLOCK_BITS * HIST_BLOCKS;
   localparam int BURST_MAX = 5;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] CNT_BLOCK = 5'h1A;
   localparam logic [4:0] CNT_START = 5'h01;
   localparam logic [2:0] LOSS_BLOCKS = 3'h5;
   localparam logic [9:0] GEN_LOW = 10'h1B9;
   localparam logic [9:0] GEN_INV = 10'h2DC;
   localparam logic [9:0] OFS_A = 10'h0FC;
   localparam logic [9:0] OFS_B = 10'h198;
   localparam logic [9:0] OFS_C = 10'h168;
   localparam logic [9:0] OFS_CP = 10'h350;
   localparam logic [9:0] OFS_D = 10'h1B4;
   localparam logic [9:0] OFS_E = 10'h000;

   typedef enum logic [1:0] {
      ST_HUNT = 2'b00,
      ST_CONF = 2'b01,
      ST_LOCK = 2'b10
   } sync_state_type;

   typedef struct packed {
      logic [INFO_BITS-1:0] data;
      logic [1:0] pos;
      logic fixed;
      logic bad;
   } block_rec_type;

   localparam int REC_BITS = $bits(block_rec_type);

   // Remainder of a block divided by the generator
   function automatic logic [9:0] syndrome(input logic [25:0] w);
      logic [9:0] s;
      s = 10'h000;
      for (int i = BLOCK_BITS - 1; i >= 0; i--) begin
         s = {s[8:0], w[i]} ^ (s[9] ? GEN_LOW : 10'h000);
      end
      return s;
   endfunction : syndrome

   function automatic logic [9:0] offset_of(input logic [1:0] pos);
      case (pos)
         2'h0: return OFS_A;
         2'h1: return OFS_B;
         2'h2: return OFS_C;
         default: return OFS_D;
      endcase
   endfunction : offset_of

   // Offset valid for position, C' in third slot, E anywhere
   function automatic logic block_hit(input logic [9:0] s,
                                      input logic [1:0] pos);
      return s == offset_of(pos) || (pos == 2'h2 && s == OFS_CP) ||
         s == OFS_E;
   endfunction : block_hit

   // Hit flag and position of a found offset
   function automatic logic [2:0] hunt_code(input logic [9:0] s);
      case (s)
         OFS_A: return 3'h4;
         OFS_B: return 3'h5;
         OFS_C: return 3'h6;
         OFS_CP: return 3'h6;
         OFS_D: return 3'h7;
         OFS_E: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction : hunt_code
endpackage : rds_pkg
